/* hdl/spd_map.svh */
// Constants, field positions and timing counts of the presence-detect link
`ifndef SPD_MAP_SVH
`define SPD_MAP_SVH
`define SPD_TYPE_MEM 4'ha
`define SPD_TYPE_PROT 4'h6
`define SPD_TYPE_HI 7
`define SPD_TYPE_LO 4
`define SPD_CE_HI 3
`define SPD_CE_LO 1
`define SPD_RW_BIT 0
`define SPD_HALF_BIT 7
`define SPD_PROT_READ_VAL 8'hff
`define SPD_CMD_ADDR 8'h00
`define SPD_STAT_ADDR 8'h04
`define SPD_CMD_START 8
`define SPD_CMD_READ 9
`define SPD_CMD_NACK 10
`define SPD_CMD_STOP 11
`define SPD_STAT_NACK 8
`define SPD_STAT_BUSY 9
`define SPD_MCLK_HZ 125000000
`define SPD_SCL_MAX_HZ 400000
`define SPD_QUARTER_CYC ((`SPD_MCLK_HZ+4*`SPD_SCL_MAX_HZ-1)/(4*`SPD_SCL_MAX_HZ))
`define SPD_QUARTER_MIN 8
`endif

/* hdl/spd_pkg.sv */
// Types shared by both ends of the presence-detect link
package spd_pkg;
  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_RX = 3'b001,
    D_ACK = 3'b011,
    D_TX = 3'b010,
    D_RACK = 3'b110
  } dev_state_t;
  typedef enum logic [2:0] {
    K_DEV, K_ADDR, K_DATA, K_PADDR, K_PDATA, K_MREAD, K_PREAD
  } byte_kind_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_START = 2'b01,
    H_BITS = 2'b11,
    H_STOP = 2'b10
  } host_state_t;
endpackage

/* hdl/spd_link_if.sv */
// Two-wire link between the bus master and the memory device
`timescale 1ns/1ps
interface spd_link_if;
  logic scl_o;
  logic scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;
  // Open-drain wires: low wins, pull-up otherwise
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~(m_sda_oe & ~m_sda_o) & ~(s_sda_oe & ~s_sda_o);
  modport host (input scl, input sda, output scl_o, output scl_oe,
    output m_sda_o, output m_sda_oe);
  modport device (input scl, input sda, output s_sda_o,
    output s_sda_oe);
endinterface

/* hdl/spd_dev_end.sv */
// Memory device end: 256-byte array, protection and read modes
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "spd_map.svh"
module spd_dev_end (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic nv_erase_n,
  spd_link_if.device link,
  input wire logic [2:0] select_pin_bits,
  input wire logic write_inhibit_n,
  output logic prot_armed
);
  import spd_pkg::*;

  logic scl_s1_ff;
  logic scl_s2_ff;
  logic scl_d_ff;
  logic sda_s1_ff;
  logic sda_s2_ff;
  logic sda_d_ff;
  logic [2:0] sel_s1_ff;
  logic [2:0] sel_s2_ff;
  logic wi_s1_ff;
  logic wi_s2_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  dev_state_t state_ff;
  byte_kind_t kind_ff;
  byte_kind_t nxt_kind;
  logic [3:0] bitcnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] addr_ff;
  logic sda_oe_ff;
  logic armed_ff;
  logic [7:0] mem_ff [256];
  logic do_ack;
  logic wr_ok;
  logic byte_end;
  logic mem_we;
  logic arm_we;
  logic [7:0] tx_byte;

  function automatic logic sel_hit(input logic [7:0] b,
    input logic [3:0] typ, input logic [2:0] pins);
    sel_hit = (b[`SPD_TYPE_HI:`SPD_TYPE_LO] == typ) &&
      (b[`SPD_CE_HI:`SPD_CE_LO] == pins);
  endfunction

  // Pins are asynchronous to mclk; two stages before any use
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      sel_s1_ff <= 3'h0;
      sel_s2_ff <= 3'h0;
      wi_s1_ff <= 1'b1;
      wi_s2_ff <= 1'b1;
    end
    else
    begin
      scl_s1_ff <= link.scl;
      scl_s2_ff <= scl_s1_ff;
      scl_d_ff <= scl_s2_ff;
      sda_s1_ff <= link.sda;
      sda_s2_ff <= sda_s1_ff;
      sda_d_ff <= sda_s2_ff;
      sel_s1_ff <= select_pin_bits;
      sel_s2_ff <= sel_s1_ff;
      wi_s1_ff <= write_inhibit_n;
      wi_s2_ff <= wi_s1_ff;
    end
  end

  assign scl_rise = scl_s2_ff & ~scl_d_ff;
  assign scl_fall = ~scl_s2_ff & scl_d_ff;
  assign start_seen = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
  assign stop_seen = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;
  assign byte_end = (state_ff == D_RX) && scl_fall && (bitcnt_ff == 4'h8);

  // Lower half refused once armed; inhibit high refuses all writes
  assign wr_ok = ~wi_s2_ff &
    ~(armed_ff & ~addr_ff[`SPD_HALF_BIT]);

  always_comb
  begin
    do_ack = 1'b0;
    nxt_kind = kind_ff;
    case (kind_ff)
      K_DEV:
      begin
        if (sel_hit(shift_ff, `SPD_TYPE_MEM, sel_s2_ff))
        begin
          do_ack = 1'b1;
          nxt_kind = shift_ff[`SPD_RW_BIT] ? K_MREAD : K_ADDR;
        end
        // Armed flag hides the protection code completely
        else if (!armed_ff &&
          sel_hit(shift_ff, `SPD_TYPE_PROT, sel_s2_ff))
        begin
          do_ack = 1'b1;
          nxt_kind = shift_ff[`SPD_RW_BIT] ? K_PREAD : K_PADDR;
        end
      end
      K_ADDR:
      begin
        do_ack = 1'b1;
        nxt_kind = K_DATA;
      end
      K_DATA:
      begin
        do_ack = wr_ok;
      end
      K_PADDR:
      begin
        do_ack = 1'b1;
        nxt_kind = K_PDATA;
      end
      K_PDATA:
      begin
        do_ack = ~wi_s2_ff & ~armed_ff;
      end
      default:
      begin
        do_ack = 1'b0;
      end
    endcase
  end

  assign mem_we = byte_end && do_ack && (kind_ff == K_DATA);
  assign arm_we = byte_end && do_ack && (kind_ff == K_PDATA);
  // Reads never look at the inhibit input
  assign tx_byte = (kind_ff == K_PREAD) ? `SPD_PROT_READ_VAL :
    mem_ff[addr_ff];

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= D_IDLE;
      kind_ff <= K_DEV;
      bitcnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      sda_oe_ff <= 1'b0;
    end
    else if (start_seen)
    begin
      state_ff <= D_RX;
      kind_ff <= K_DEV;
      bitcnt_ff <= 4'h0;
      sda_oe_ff <= 1'b0;
    end
    else if (stop_seen)
    begin
      state_ff <= D_IDLE;
      sda_oe_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        D_RX:
        begin
          if (scl_rise)
          begin
            shift_ff <= {shift_ff[6:0], sda_s2_ff};
            bitcnt_ff <= bitcnt_ff + 4'h1;
          end
          else if (byte_end)
          begin
            // Mismatch or refusal leaves the line released
            state_ff <= do_ack ? D_ACK : D_IDLE;
            sda_oe_ff <= do_ack;
            kind_ff <= nxt_kind;
          end
        end
        D_ACK:
        begin
          if (scl_fall)
          begin
            if (kind_ff == K_MREAD || kind_ff == K_PREAD)
            begin
              shift_ff <= tx_byte;
              sda_oe_ff <= ~tx_byte[7];
              bitcnt_ff <= 4'h1;
              state_ff <= D_TX;
            end
            else
            begin
              sda_oe_ff <= 1'b0;
              bitcnt_ff <= 4'h0;
              state_ff <= D_RX;
            end
          end
        end
        D_TX:
        begin
          if (scl_fall)
          begin
            if (bitcnt_ff == 4'h8)
            begin
              sda_oe_ff <= 1'b0;
              state_ff <= D_RACK;
            end
            else
            begin
              sda_oe_ff <= ~shift_ff[6];
              shift_ff <= {shift_ff[6:0], 1'b0};
              bitcnt_ff <= bitcnt_ff + 4'h1;
            end
          end
        end
        D_RACK:
        begin
          // Released line in the ninth slot ends the read
          if (scl_rise && sda_s2_ff)
          begin
            state_ff <= D_IDLE;
          end
          else if (scl_fall)
          begin
            shift_ff <= tx_byte;
            sda_oe_ff <= ~tx_byte[7];
            bitcnt_ff <= 4'h1;
            state_ff <= D_TX;
          end
        end
        default:
        begin
          sda_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  // Address counter: load, page step on writes, full wrap on reads
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      addr_ff <= 8'h00;
    end
    else if (byte_end && do_ack && kind_ff == K_ADDR)
    begin
      addr_ff <= shift_ff;
    end
    else if (mem_we)
    begin
      addr_ff <= {addr_ff[7:4], addr_ff[3:0] + 4'h1};
    end
    else if (kind_ff == K_MREAD && scl_fall &&
      (state_ff == D_ACK || (state_ff == D_RACK && !start_seen &&
      !stop_seen)))
    begin
      addr_ff <= addr_ff + 8'h01;
    end
  end

  // Array contents are nonvolatile: no reset
  always_ff @(posedge mclk)
  begin
    if (mem_we)
    begin
      mem_ff[addr_ff] <= shift_ff;
    end
  end

  // Only the factory erase input clears it, never arst_n
  always_ff @(posedge mclk or negedge nv_erase_n)
  begin
    if (!nv_erase_n)
    begin
      armed_ff <= 1'b0;
    end
    else if (arm_we && !start_seen && !stop_seen)
    begin
      armed_ff <= 1'b1;
    end
  end

  assign prot_armed = armed_ff;
  assign link.s_sda_o = 1'b0;
  assign link.s_sda_oe = sda_oe_ff;
endmodule

/* hdl/spd_host_end.sv */
// Bus master end: byte-level command engine driving the link
`timescale 1ns/1ps
`include "spd_map.svh"
module spd_host_end #(
  parameter int QUARTER = `SPD_QUARTER_CYC
) (
  input wire logic mclk,
  input wire logic arst_n,
  spd_link_if.host link,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);
  import spd_pkg::*;

  generate
    if (QUARTER < `SPD_QUARTER_MIN || QUARTER > 65535)
    begin : g_bad
      $error("QUARTER out of range");
    end
  endgenerate

  host_state_t state_ff;
  logic [15:0] qcnt_ff;
  logic [1:0] quarter_ff;
  logic [3:0] bitcnt_ff;
  logic [8:0] txv_ff;
  logic [8:0] rxv_ff;
  logic scl_low_ff;
  logic sda_low_ff;
  logic busy_ff;
  logic nack_ff;
  logic [7:0] rxbyte_ff;
  logic sda_s1_ff;
  logic sda_s2_ff;
  logic [31:0] rdata_ff;
  logic qtick;
  logic cmd_take;

  assign qtick = busy_ff && (qcnt_ff == 16'(QUARTER - 1));
  // Commands written while busy are dropped; software polls busy
  assign cmd_take = wr && (addr == `SPD_CMD_ADDR) && !busy_ff;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
    end
    else
    begin
      sda_s1_ff <= link.sda;
      sda_s2_ff <= sda_s1_ff;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      qcnt_ff <= 16'h0000;
    end
    else if (cmd_take || qtick)
    begin
      qcnt_ff <= 16'h0000;
    end
    else if (busy_ff)
    begin
      qcnt_ff <= qcnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= H_IDLE;
      quarter_ff <= 2'h0;
      bitcnt_ff <= 4'h0;
      txv_ff <= 9'h1ff;
      rxv_ff <= 9'h000;
      scl_low_ff <= 1'b0;
      sda_low_ff <= 1'b0;
      busy_ff <= 1'b0;
      nack_ff <= 1'b0;
      rxbyte_ff <= 8'h00;
    end
    else if (cmd_take)
    begin
      busy_ff <= 1'b1;
      quarter_ff <= 2'h0;
      bitcnt_ff <= 4'h0;
      // Read releases data and sends the ack choice in slot nine
      txv_ff <= wdata[`SPD_CMD_READ] ? {8'hff, wdata[`SPD_CMD_NACK]} :
        {wdata[7:0], 1'b1};
      if (wdata[`SPD_CMD_STOP])
        state_ff <= H_STOP;
      else if (wdata[`SPD_CMD_START])
        state_ff <= H_START;
      else
        state_ff <= H_BITS;
    end
    else if (qtick)
    begin
      quarter_ff <= quarter_ff + 2'h1;
      case (state_ff)
        H_START:
        begin
          case (quarter_ff)
            2'h0:
            begin
              sda_low_ff <= 1'b0;
              scl_low_ff <= 1'b1;
            end
            2'h1: scl_low_ff <= 1'b0;
            2'h2: sda_low_ff <= 1'b1;
            default:
            begin
              scl_low_ff <= 1'b1;
              state_ff <= H_BITS;
            end
          endcase
        end
        H_BITS:
        begin
          case (quarter_ff)
            2'h0: sda_low_ff <= ~txv_ff[8];
            2'h1: scl_low_ff <= 1'b0;
            2'h2: rxv_ff <= {rxv_ff[7:0], sda_s2_ff};
            default:
            begin
              scl_low_ff <= 1'b1;
              txv_ff <= {txv_ff[7:0], 1'b1};
              bitcnt_ff <= bitcnt_ff + 4'h1;
              if (bitcnt_ff == 4'h8)
              begin
                busy_ff <= 1'b0;
                nack_ff <= rxv_ff[0];
                rxbyte_ff <= rxv_ff[8:1];
                state_ff <= H_IDLE;
              end
            end
          endcase
        end
        H_STOP:
        begin
          case (quarter_ff)
            2'h0:
            begin
              sda_low_ff <= 1'b1;
              scl_low_ff <= 1'b1;
            end
            2'h1: scl_low_ff <= 1'b0;
            2'h2: sda_low_ff <= 1'b0;
            default:
            begin
              busy_ff <= 1'b0;
              state_ff <= H_IDLE;
            end
          endcase
        end
        default:
        begin
          busy_ff <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_ff <= 32'h00000000;
    else if (rd && addr == `SPD_STAT_ADDR)
      rdata_ff <= {22'h000000, busy_ff, nack_ff, rxbyte_ff};
    else
      rdata_ff <= 32'h00000000;
  end

  assign rdata = rdata_ff;
  assign link.scl_o = 1'b0;
  assign link.scl_oe = scl_low_ff;
  assign link.m_sda_o = 1'b0;
  assign link.m_sda_oe = sda_low_ff;
endmodule

/* bench/spd_link_sva.sv */
// Timing checker for the two-wire link between both ends
`timescale 1ns/1ps
module spd_link_sva #(
  parameter int QUARTER = 8
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe
);
  logic [7:0] low_ff;
  logic [15:0] drv_ff;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Cycles since clock fell, saturating
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n) low_ff <= 8'h00;
    else if (scl) low_ff <= 8'h00;
    else if (low_ff != 8'hff) low_ff <= low_ff + 8'h01;
  // Run length of device drive; ack slot plus 8 data slots at most
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n) drv_ff <= 16'h0000;
    else if (!s_sda_oe) drv_ff <= 16'h0000;
    else if (drv_ff != 16'hffff) drv_ff <= drv_ff + 16'h0001;
  property p_dev_steady;
    scl && $past(scl) |-> $stable(s_sda_oe);
  endproperty
  a_dev_steady: assert property (p_dev_steady)
    else $error("device data moved while clock high");
  property p_dev_low;
    s_sda_oe |-> !s_sda_o && !sda;
  endproperty
  a_dev_low: assert property (p_dev_low)
    else $error("device drive does not pull data low");
  property p_start_free;
    $fell(sda) && scl |-> !s_sda_oe && m_sda_oe;
  endproperty
  a_start_free: assert property (p_start_free)
    else $error("start not made by master alone");
  property p_stop_quiet;
    $rose(sda) && scl |=> !s_sda_oe [*8];
  endproperty
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("device drives after stop");
  property p_drive_prompt;
    $rose(s_sda_oe) |-> !scl && low_ff <= 8'd8;
  endproperty
  a_drive_prompt: assert property (p_drive_prompt)
    else $error("device drive late or during clock high");
  property p_release_prompt;
    $fell(s_sda_oe) |-> !scl && low_ff <= 8'd8;
  endproperty
  a_release_prompt: assert property (p_release_prompt)
    else $error("device release late or during clock high");
  property p_byte_bound;
    s_sda_oe |-> int'(drv_ff) <= 36 * QUARTER + 16;
  endproperty
  a_byte_bound: assert property (p_byte_bound)
    else $error("device held data past one byte");
  property p_scl_low_held;
    $fell(scl) |=> !scl [*7];
  endproperty
  a_scl_low_held: assert property (p_scl_low_held)
    else $error("clock low phase too short");
  c_start: cover property ($fell(sda) && scl);
  c_stop: cover property ($rose(sda) && scl);
  c_dev_drive: cover property ($rose(s_sda_oe));
endmodule

/* bench/eeprom_protect_and_read_slave_tb.sv */
// Bench: both link ends joined, driven through the host register port
`timescale 1ns/1ps
module eeprom_protect_and_read_slave_tb;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic nv_erase_n = 1'b0;
  logic [2:0] select_pin_bits = 3'b000;
  logic write_inhibit_n = 1'b0;
  logic prot_armed;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  int bad_count = 0;
  int total_checks = 0;
  always #4 mclk = ~mclk;
  spd_link_if link_bus ();
  spd_host_end #(.QUARTER(8)) spd_host_end_inst (.mclk(mclk),
    .arst_n(arst_n), .link(link_bus), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  spd_dev_end spd_dev_end_inst (.mclk(mclk), .arst_n(arst_n),
    .nv_erase_n(nv_erase_n), .link(link_bus),
    .select_pin_bits(select_pin_bits),
    .write_inhibit_n(write_inhibit_n), .prot_armed(prot_armed));
  spd_link_sva #(.QUARTER(8)) spd_link_chk_inst (.mclk(mclk),
    .arst_n(arst_n), .scl(link_bus.scl), .sda(link_bus.sda),
    .m_sda_oe(link_bus.m_sda_oe), .s_sda_o(link_bus.s_sda_o),
    .s_sda_oe(link_bus.s_sda_oe));
  task final_report;
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [8:0] e, input logic [8:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  // One command, then poll busy with a status read every second cycle
  task cmd(input logic [11:0] v, output logic [31:0] st);
    int n;
    n = 0;
    wr <= 1'b1;
    addr <= 8'h00;
    wdata <= {20'h0, v};
    @(posedge mclk);
    wr <= 1'b0;
    do
    begin
      rd <= 1'b1;
      addr <= 8'h04;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      st = rdata;
      @(posedge mclk);
      n++;
    end while (st[9] !== 1'b0 && n < 2000);
    // A stuck engine ends the run here, not at the watchdog
    if (st[9] !== 1'b0)
    begin
      $display("wrong value busy expected 0 seen %b", st[9]);
      bad_count++;
      final_report();
    end
  endtask
  task snd(input logic s, input logic [7:0] b, input logic nk);
    logic [31:0] st;
    cmd({3'b000, s, b}, st);
    chk("byte_sent", {nk, b}, st[8:0]);
  endtask
  task rcv(input logic nk, input logic [7:0] e);
    logic [31:0] st;
    cmd({1'b0, nk, 2'b10, 8'h00}, st);
    chk("byte_read", {1'b0, e}, {1'b0, st[7:0]});
  endtask
  task stp;
    logic [31:0] st;
    cmd(12'h800, st);
  endtask
  task wrb(input logic [7:0] a, input logic [7:0] d, input logic nk);
    snd(1'b1, 8'ha0, 1'b0);
    snd(1'b0, a, 1'b0);
    snd(1'b0, d, nk);
    stp();
  endtask
  // Dummy write to load the counter, then restart as a read
  task rrd(input logic [7:0] a);
    snd(1'b1, 8'ha0, 1'b0);
    snd(1'b0, a, 1'b0);
    snd(1'b1, 8'ha1, 1'b0);
  endtask
  task t_shipped;
    chk("prot_armed", 9'h000, {8'h00, prot_armed});
    wrb(8'h10, 8'h55, 1'b0);
    wrb(8'h90, 8'h66, 1'b0);
    wrb(8'hff, 8'h77, 1'b0);
    snd(1'b1, 8'ha0, 1'b0);
    snd(1'b0, 8'h00, 1'b0);
    snd(1'b0, 8'h11, 1'b0);
    snd(1'b0, 8'h22, 1'b0);
    stp();
  endtask
  task t_reads;
    rrd(8'hff);
    rcv(1'b0, 8'h77);
    rcv(1'b0, 8'h11);
    rcv(1'b1, 8'h22);
    stp();
    rrd(8'h00);
    rcv(1'b1, 8'h11);
    stp();
    snd(1'b1, 8'ha1, 1'b0);
    rcv(1'b1, 8'h22);
    stp();
  endtask
  task t_select;
    snd(1'b1, 8'ha2, 1'b1);
    stp();
    snd(1'b1, 8'hb0, 1'b1);
    stp();
    snd(1'b1, 8'h61, 1'b0);
    rcv(1'b1, 8'hff);
    stp();
    // Non-zero straps: select must follow the pins, not a fixed code
    select_pin_bits <= 3'b101;
    snd(1'b1, 8'haa, 1'b0);
    stp();
    snd(1'b1, 8'ha0, 1'b1);
    stp();
    select_pin_bits <= 3'b000;
  endtask
  task t_inhibit;
    write_inhibit_n <= 1'b1;
    wrb(8'h90, 8'h99, 1'b1);
    wrb(8'h60, 8'h00, 1'b1);
    snd(1'b1, 8'h60, 1'b0);
    snd(1'b0, 8'h00, 1'b0);
    snd(1'b0, 8'h00, 1'b1);
    stp();
    chk("prot_armed", 9'h000, {8'h00, prot_armed});
    rrd(8'h90);
    rcv(1'b1, 8'h66);
    stp();
    write_inhibit_n <= 1'b0;
  endtask
  task t_arm;
    snd(1'b1, 8'h60, 1'b0);
    snd(1'b0, 8'h5a, 1'b0);
    snd(1'b0, 8'hc3, 1'b0);
    stp();
    chk("prot_armed", 9'h001, {8'h00, prot_armed});
    snd(1'b1, 8'h60, 1'b1);
    stp();
    snd(1'b1, 8'h61, 1'b1);
    stp();
    wrb(8'h10, 8'haa, 1'b1);
    rrd(8'h10);
    rcv(1'b1, 8'h55);
    stp();
    wrb(8'h90, 8'hbb, 1'b0);
    rrd(8'h90);
    rcv(1'b1, 8'hbb);
    stp();
    arst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    chk("prot_armed", 9'h001, {8'h00, prot_armed});
    snd(1'b1, 8'h60, 1'b1);
    stp();
  endtask
  // Run needs about 20500 cycles; the limit allows over twice that
  initial
  begin
    #400000;
    $display("wrong value watchdog expected done seen timeout");
    bad_count++;
    final_report();
  end
  initial
  begin
    repeat (2) @(posedge mclk);
    nv_erase_n <= 1'b1;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    t_shipped();
    t_reads();
    t_select();
    t_inhibit();
    t_arm();
    final_report();
  end
endmodule
